//--- hw/erc_regs.vh
// Register map, field positions and reset values of the encoder
// period-reload and position-compare block.
// Assumes a 32-bit APB slave decoding byte addresses on aligned words.
`ifndef ERC_REGS_VH
`define ERC_REGS_VH

// Bus geometry
`define ERC_ADDR_W        8
`define ERC_DATA_W        32

// Register byte offsets
`define ERC_OFF_CTRL      8'h00
`define ERC_OFF_PERIOD    8'h04
`define ERC_OFF_COMPARE   8'h08
`define ERC_OFF_COUNT     8'h0C
`define ERC_OFF_STATUS    8'h10
`define ERC_OFF_IRQ_EN    8'h14
`define ERC_OFF_IRQ_CLR   8'h18

// Control register fields
`define ERC_CTRL_RUN      0
`define ERC_CTRL_ZEN      1
`define ERC_CTRL_CMPEN    2
`define ERC_CTRL_INTEN    3
`define ERC_CTRL_MODE_LO  4
`define ERC_CTRL_MODE_HI  5
`define ERC_CTRL_CNTCLR   6
`define ERC_CTRL_W        6

// Operating modes
`define ERC_MODE_ENCODER  2'h0
`define ERC_MODE_SNS_EVT  2'h1
`define ERC_MODE_SNS_TMR  2'h2
`define ERC_MODE_TIMER    2'h3

// Status, enable and clear share this layout
`define ERC_ST_MATCH      0
`define ERC_ST_ZDET       1
`define ERC_ST_MIRQ       2
`define ERC_ST_W          3
`define ERC_ST_DIR        3

// Field widths
`define ERC_PERIOD_W      16
`define ERC_COMPARE_W     24
`define ERC_CNT_W         16

// Reset values
`define ERC_CTRL_RST      6'h00
`define ERC_PERIOD_RST    16'h0000
`define ERC_COMPARE_RST   24'h000000
`define ERC_ST_RST        3'h0

`endif

//--- hw/erc_quad_decode.v
// Quadrature decoder: synchronises A, B and Z, and yields the times-four
// count tick, the direction and the index edges as one-cycle pulses.
// Assumes A, B and Z arrive asynchronously from the encoder pins.
`timescale 1ns/1ps
module erc_quad_decode (
  clk,
  rstn,
  enc_a,
  enc_b,
  enc_z,
  tick,
  dir_up,
  z_rise,
  z_fall
);
  input  wire clk;
  input  wire rstn;
  input  wire enc_a;
  input  wire enc_b;
  input  wire enc_z;
  output wire tick;
  output wire dir_up;
  output wire z_rise;
  output wire z_fall;

  wire [2:0] pin_in;
  reg  [2:0] meta_r;
  reg  [2:0] sync_r;
  reg  [2:0] prev_r;

  assign pin_in = {enc_z, enc_b, enc_a};

  // Two-flop synchroniser per pin; only sync_r reads meta_r
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always @(posedge clk) begin
        if (!rstn) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= pin_in[gi];
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
    end
  endgenerate

  // Every edge of A or B is one tick; a double change is a glitch and dropped
  assign tick   = (sync_r[0] ^ prev_r[0]) ^ (sync_r[1] ^ prev_r[1]);
  // A leading B counts up: new A against the B level before this edge
  assign dir_up = sync_r[0] ^ prev_r[1];
  assign z_rise = sync_r[2] & ~prev_r[2];
  assign z_fall = ~sync_r[2] & prev_r[2];
endmodule

//--- hw/erc_reload_compare.v
// Encoder position counter with period reload and position compare,
// an APB register slave and one level interrupt output.
// Assumes A, B, Z come straight from pins and the APB master runs on clk.
//
// Notes on behaviour
// - 16-bit read/write period register sets counter period in x4 ticks.
// - Counting up, counter reaches period, then wraps to zero next tick.
// - Counting down, counter reaches zero, then loads period next tick.
// - Period only steers counting in encoder mode; other modes ignore it.
// - 24-bit read/write compare register; bits 31 to 24 read zero.
// - In encoder mode compare acts as position condition, range 0 to 65535.
// - With match enabled, counter equal to compare low half sets match flag.
// - Match with interrupt enable set raises the encoder interrupt request.
// - With index use on, match interrupt waits until index flag is set.
// - Count tick is the times-four clock decoded from A and B.
// - Index pulse seen while running sets the index-detected flag; the code also needs index use on and encoder mode.
// - Compare bits 23 to 16 never take part in encoder mode.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "erc_regs.vh"
module erc_reload_compare (
  clk,
  rstn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  enc_a,
  enc_b,
  enc_z,
  encoder_irq_request
);
  input  wire                     clk;
  input  wire                     rstn;
  input  wire                     psel;
  input  wire                     penable;
  input  wire                     pwrite;
  input  wire [`ERC_ADDR_W-1:0]   paddr;
  input  wire [`ERC_DATA_W-1:0]   pwdata;
  output reg  [`ERC_DATA_W-1:0]   prdata;
  output reg                      pready;
  output reg                      pslverr;
  input  wire                     enc_a;
  input  wire                     enc_b;
  input  wire                     enc_z;
  output reg                      encoder_irq_request;

  // Control and data registers
  reg  [`ERC_CTRL_W-1:0]      ctrl_r;
  reg  [`ERC_PERIOD_W-1:0]    period_r;
  reg  [`ERC_COMPARE_W-1:0]   compare_r;
  reg  [`ERC_CNT_W-1:0]       cnt_r;
  reg  [`ERC_CNT_W-1:0]       cnt_nxt;
  reg                         cnt_upd_r;
  reg                         dir_r;
  reg  [`ERC_ST_W-1:0]        status_r;
  reg  [`ERC_ST_W-1:0]        status_nxt;
  reg  [`ERC_ST_W-1:0]        irq_en_r;
  reg  [`ERC_DATA_W-1:0]      rdata_nxt;
  reg                         hit_nxt;

  // Decoder outputs
  wire                        tick;
  wire                        dir_up;
  wire                        z_rise;
  wire                        z_fall;

  // Field views
  wire                        run;
  wire                        zen;
  wire                        cmpen;
  wire                        inten;
  wire [1:0]                  mode;
  wire                        enc_mode;

  // Bus strobes
  wire                        setup;
  wire                        access;
  wire                        wr_en;
  wire [`ERC_ADDR_W-1:0]      addr_w;

  // Events
  wire                        z_event;
  wire                        match_ev;
  wire                        mirq_ev;
  wire [`ERC_ST_W-1:0]        set_vec;
  wire [`ERC_ST_W-1:0]        clr_vec;

  assign run      = ctrl_r[`ERC_CTRL_RUN];
  assign zen      = ctrl_r[`ERC_CTRL_ZEN];
  assign cmpen    = ctrl_r[`ERC_CTRL_CMPEN];
  assign inten    = ctrl_r[`ERC_CTRL_INTEN];
  assign mode     = ctrl_r[`ERC_CTRL_MODE_HI:`ERC_CTRL_MODE_LO];
  assign enc_mode = (mode == `ERC_MODE_ENCODER);

  // Pin synchronisation and x4 decoding live in the leaf
  erc_quad_decode u_dec (
    .clk    (clk),
    .rstn   (rstn),
    .enc_a  (enc_a),
    .enc_b  (enc_b),
    .enc_z  (enc_z),
    .tick   (tick),
    .dir_up (dir_up),
    .z_rise (z_rise),
    .z_fall (z_fall)
  );

  // APB phases; pready is raised for exactly one access cycle
  assign setup  = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr_en  = access & pwrite;
  assign addr_w = {paddr[`ERC_ADDR_W-1:2], 2'b00};

  // Index edge in the direction of travel: rising going up, falling going down.
  // The last tick's direction is used, since dir_up means nothing between ticks.
  assign z_event = run & enc_mode & zen & ((z_rise & dir_r) | (z_fall & ~dir_r));

  // Next counter value
  always @* begin
    cnt_nxt = cnt_r;
    if (wr_en && (addr_w == `ERC_OFF_CTRL) && pwdata[`ERC_CTRL_CNTCLR]) begin
      cnt_nxt = {`ERC_CNT_W{1'b0}};
    end else if (z_event) begin
      // Index clear takes precedence over a coincident tick
      cnt_nxt = {`ERC_CNT_W{1'b0}};
    end else if (run && tick) begin
      if (enc_mode) begin
        if (dir_up) begin
          if (cnt_r == period_r) begin
            cnt_nxt = {`ERC_CNT_W{1'b0}};
          end else begin
            cnt_nxt = cnt_r + 16'h0001;
          end
        end else begin
          if (cnt_r == 16'h0000) begin
            cnt_nxt = period_r;
          end else begin
            cnt_nxt = cnt_r - 16'h0001;
          end
        end
      end else begin
        // Other modes wrap at full scale; the period plays no part here
        if (dir_up) begin
          cnt_nxt = cnt_r + 16'h0001;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
    end
  end

  // Counter, its update marker and the rotation direction
  always @(posedge clk) begin
    if (!rstn) begin
      cnt_r     <= {`ERC_CNT_W{1'b0}};
      cnt_upd_r <= 1'b0;
      dir_r     <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      cnt_upd_r <= (cnt_nxt != cnt_r) | (run & tick);
      if (!run) begin
        dir_r <= 1'b0;
      end else if (tick) begin
        dir_r <= dir_up;
      end
    end
  end

  // Compare uses only the low half in encoder mode, so the upper byte is
  // inert here; no mode compares it, it is only stored and read back.
  always @* begin
    hit_nxt = 1'b0;
    if (run && enc_mode && cmpen && cnt_upd_r) begin
      hit_nxt = (cnt_r == compare_r[15:0]);
    end
  end

  assign match_ev = hit_nxt;
  // Held back while the index is in use and not yet seen
  assign mirq_ev  = match_ev & inten & (~zen | status_r[`ERC_ST_ZDET]);

  assign set_vec = {mirq_ev, z_event, match_ev};
  assign clr_vec = (wr_en && (addr_w == `ERC_OFF_IRQ_CLR)) ?
                   pwdata[`ERC_ST_W-1:0] : {`ERC_ST_W{1'b0}};

  // Sticky flags: a set in the clearing cycle wins; stopping clears them all
  always @* begin
    if (!run) begin
      status_nxt = `ERC_ST_RST;
    end else begin
      status_nxt = (status_r & ~clr_vec) | set_vec;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      status_r <= `ERC_ST_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Software-written registers
  always @(posedge clk) begin
    if (!rstn) begin
      ctrl_r    <= `ERC_CTRL_RST;
      period_r  <= `ERC_PERIOD_RST;
      compare_r <= `ERC_COMPARE_RST;
      irq_en_r  <= `ERC_ST_RST;
    end else if (wr_en) begin
      case (addr_w)
        `ERC_OFF_CTRL: begin
          ctrl_r <= pwdata[`ERC_CTRL_W-1:0];
        end
        `ERC_OFF_PERIOD: begin
          period_r <= pwdata[`ERC_PERIOD_W-1:0];
        end
        `ERC_OFF_COMPARE: begin
          compare_r <= pwdata[`ERC_COMPARE_W-1:0];
        end
        `ERC_OFF_IRQ_EN: begin
          irq_en_r <= pwdata[`ERC_ST_W-1:0];
        end
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // Read multiplexer; unused upper bits are zero
  always @* begin
    rdata_nxt = {`ERC_DATA_W{1'b0}};
    case (addr_w)
      `ERC_OFF_CTRL: begin
        rdata_nxt[`ERC_CTRL_W-1:0] = ctrl_r;
      end
      `ERC_OFF_PERIOD: begin
        rdata_nxt[`ERC_PERIOD_W-1:0] = period_r;
      end
      `ERC_OFF_COMPARE: begin
        rdata_nxt[`ERC_COMPARE_W-1:0] = compare_r;
      end
      `ERC_OFF_COUNT: begin
        rdata_nxt[`ERC_CNT_W-1:0] = cnt_r;
      end
      `ERC_OFF_STATUS: begin
        rdata_nxt[`ERC_ST_W-1:0] = status_r;
        rdata_nxt[`ERC_ST_DIR]   = dir_r;
      end
      `ERC_OFF_IRQ_EN: begin
        rdata_nxt[`ERC_ST_W-1:0] = irq_en_r;
      end
      default: begin
        rdata_nxt = {`ERC_DATA_W{1'b0}};
      end
    endcase
  end

  // Bus answer: one wait-free access phase after every setup cycle.
  // Registering pready costs nothing since APB always spends one setup cycle.
  always @(posedge clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= {`ERC_DATA_W{1'b0}};
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= pwrite ? {`ERC_DATA_W{1'b0}} : rdata_nxt;
        pslverr <= (addr_w > `ERC_OFF_IRQ_CLR);
      end else begin
        prdata  <= {`ERC_DATA_W{1'b0}};
        pslverr <= 1'b0;
      end
    end
  end

  // Level interrupt from flags and enables; registered so it leaves a flop
  always @(posedge clk) begin
    if (!rstn) begin
      encoder_irq_request <= 1'b0;
    end else begin
      encoder_irq_request <= |(status_nxt & irq_en_r);
    end
  end
endmodule

//--- verif/erc_enc_model.sv
// Encoder model driving A, B and Z toward the block.
// Assumes callers enter its tasks right after a rising clock edge.
`timescale 1ns/1ps
module erc_enc_model (
  input  wire logic clk,
  output logic      enc_a,
  output logic      enc_b,
  output logic      enc_z
);
  logic [1:0] ph_r;
  initial begin
    ph_r = 2'h0;
    {enc_a, enc_b, enc_z} = 3'h0;
  end
  // One A or B edge, A leading B going up; 4 clocks keeps levels above 3
  task step(input logic up);
    begin
      ph_r = up ? ph_r + 2'h1 : ph_r - 2'h1;
      enc_a <= ph_r[1] ^ ph_r[0];
      enc_b <= ph_r[1];
      repeat (4) @(posedge clk);
    end
  endtask
  // Index pulse; Z rests low between pulses
  task pulse_z;
    begin
      enc_z <= 1'b1;
      repeat (4) @(posedge clk);
      enc_z <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

//--- verif/erc_rc_chk.sv
// Checker on the top ports of the reload/compare block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module erc_rc_chk (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        enc_a,
  input wire logic        enc_b,
  input wire logic        enc_z,
  input wire logic        encoder_irq_request
);
  logic [2:0] pin_q;
  logic [3:0] quiet_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Cycles since a bus access or pin change; irq has settled after 5
  always @(posedge clk) begin
    if (!rstn) begin
      pin_q <= 3'h0;
      quiet_r <= 4'h0;
    end else begin
      pin_q <= {enc_a, enc_b, enc_z};
      if (psel || pin_q != {enc_a, enc_b, enc_z}) quiet_r <= 4'h0;
      else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
    end
  end
  a_setup_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_high: assert property (pready && paddr[7:2] > 6'h06 |-> pslverr)
    else $error("no error on unmapped");
  a_err_only: assert property (pslverr |-> pready && paddr[7:2] > 6'h06)
    else $error("stray error");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("stray read data");
  a_period_high: assert property (pready && !pwrite && paddr[7:2] == 6'h01
    |-> prdata[31:16] == 16'h0) else $error("period upper bits");
  a_compare_high: assert property (pready && !pwrite && paddr[7:2] == 6'h02
    |-> prdata[31:24] == 8'h0) else $error("compare upper bits");
  a_irq_settled: assert property (quiet_r >= 4'h6 |-> $stable(encoder_irq_request))
    else $error("irq moved without cause");
  c_write: cover property (pready && pwrite);
  c_error: cover property (pslverr);
  c_irq: cover property ($rose(encoder_irq_request));
endmodule
bind erc_reload_compare erc_rc_chk i_erc_rc_chk (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
  .encoder_irq_request(encoder_irq_request));

//--- verif/tb_erc_reload_compare.sv
// Self-checking bench: APB master plus encoder model around the block.
// Assumes the design, its header and the encoder model compile first.
`timescale 1ns/1ps
module tb_erc_reload_compare;
  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        enc_a;
  logic        enc_b;
  logic        enc_z;
  logic        irq;
  logic [31:0] rd_r;
  logic        err_r;
  int          num_errors;
  int          checked;
  // Idle bus and reset asserted from time zero
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    checked = 0;
  end
  always #10 clk = ~clk;
  erc_reload_compare i_erc_reload_compare (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
    .encoder_irq_request(irq));
  erc_enc_model i_erc_enc_model (.clk(clk), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z));
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    begin
      checked++;
      if (got !== exp) begin
        num_errors++;
        $display("FAIL %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // One APB transfer; a lost pready is left to the watchdog
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
        @(posedge clk);
      end
      rd_r = prdata;
      err_r = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      chk(nm, rd_r, exp);
    end
  endtask
  // Direction bit is masked off; only the three event flags matter here
  task rds(input string nm, input logic [31:0] exp);
    begin
      bus(1'b0, 8'h10, 32'h0);
      chk(nm, rd_r & 32'h7, exp);
    end
  endtask
  task t_regs;
    begin
      rdc("period rst", 8'h04, 32'h0);
      rdc("compare rst", 8'h08, 32'h0);
      bus(1'b1, 8'h04, 32'hFFFFFFFF);
      rdc("period rw", 8'h04, 32'h0000FFFF);
      bus(1'b1, 8'h08, 32'hFFFFFFFF);
      rdc("compare rw", 8'h08, 32'h00FFFFFF);
      bus(1'b0, 8'h1C, 32'h0);
      chk("unmapped", {31'h0, err_r}, 32'h1);
      $display("t_regs done");
    end
  endtask
  task t_wrap;
    begin
      bus(1'b1, 8'h04, 32'h3);
      bus(1'b1, 8'h00, 32'h1);
      for (int i = 1; i <= 4; i++) begin
        i_erc_enc_model.step(1'b1);
        rdc("count up", 8'h0C, i % 4);
      end
      i_erc_enc_model.step(1'b0);
      rdc("count reload", 8'h0C, 32'h3);
      i_erc_enc_model.step(1'b1);
      rdc("count wrap", 8'h0C, 32'h0);
      // Timer mode counts freely: down from zero gives full scale, not the period
      bus(1'b1, 8'h00, 32'h31);
      i_erc_enc_model.step(1'b0);
      rdc("free count", 8'h0C, 32'h0000FFFF);
      i_erc_enc_model.step(1'b1);
      rdc("free wrap", 8'h0C, 32'h0);
      $display("t_wrap done");
    end
  endtask
  // Upper compare byte set on purpose: encoder mode must ignore it
  task t_match;
    begin
      bus(1'b1, 8'h08, 32'h00FF0002);
      bus(1'b1, 8'h14, 32'h4);
      bus(1'b1, 8'h00, 32'h0D);
      i_erc_enc_model.step(1'b1);
      i_erc_enc_model.step(1'b1);
      rds("match", 32'h5);
      chk("irq set", {31'h0, irq}, 32'h1);
      bus(1'b1, 8'h18, 32'h7);
      rds("no rematch", 32'h0);
      chk("irq clear", {31'h0, irq}, 32'h0);
      i_erc_enc_model.step(1'b0);
      i_erc_enc_model.step(1'b1);
      rds("rearrive", 32'h5);
      $display("t_match done");
    end
  endtask
  task t_index;
    begin
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h14, 32'h4);
      bus(1'b1, 8'h00, 32'h0F);
      i_erc_enc_model.step(1'b0);
      i_erc_enc_model.step(1'b1);
      rds("held back", 32'h1);
      chk("irq held", {31'h0, irq}, 32'h0);
      i_erc_enc_model.pulse_z;
      rds("index seen", 32'h3);
      i_erc_enc_model.step(1'b1);
      i_erc_enc_model.step(1'b1);
      rds("released", 32'h7);
      chk("irq index", {31'h0, irq}, 32'h1);
      $display("t_index done");
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Whole run is a few hundred cycles; 10000 cycles means a hang
  initial begin
    #200000;
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_wrap;
    t_match;
    t_index;
    complete_run;
  end
endmodule
